// ---- verification/oar_resolver_monitor.sv ----
// bus timing and state-output checks for the operand address resolver
// assumes a bind from tb onto oar_resolver, one hclk domain
`timescale 1ns/1ps
`default_nettype none
module oar_resolver_monitor
  import oar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [3:0] effective_data_bank,
  input wire logic operand_error,
  input wire logic carry_bit_acc,
  input wire logic [7:0] wide_accumulator
);
  logic any_t;
  logic rd_t;
  // state only moves one or two edges after a taken write
  logic quiet;
  assign any_t = hready & hsel & htrans[1];
  assign rd_t = any_t & !hwrite;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk) quiet <= !$past(any_t, 1) && !$past(any_t, 2);
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  read_wait_a: assert property (rd_t |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (any_t && hwrite |=> hreadyout)
    else $error("write stalled");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(rd_t) || $past(rd_t, 2))
    else $error("read data moved without a read");
  bank_legal_a: assert property (effective_data_bank inside {4'h0, 4'hf})
    else $error("bank neither 0 nor 15");
  acc_quiet_a: assert property (quiet && !$past(any_t) |-> $stable(wide_accumulator))
    else $error("accumulator moved untouched");
  carry_quiet_a: assert property (quiet && !$past(any_t) |-> $stable(carry_bit_acc))
    else $error("carry moved untouched");
  decode_quiet_a: assert property (quiet && !$past(any_t) |-> $stable(effective_data_bank))
    else $error("bank moved untouched");
  error_quiet_a: assert property (quiet && !$past(any_t) |-> $stable(operand_error))
    else $error("error flag moved untouched");
  // operand write seen in its data phase; bank shows two edges later
  logic opnd_wr;
  logic fast_wr;
  logic ptr_wr;
  always_ff @(posedge hclk) opnd_wr <= any_t && hwrite && (haddr[7:0] == OAR_OPND_OFF);
  assign fast_wr = opnd_wr && (hwdata[4:0] == OAR_C_FMEM || hwdata[4:0] == OAR_C_PMEM);
  assign ptr_wr = opnd_wr && (hwdata[4:0] == OAR_C_RPTR);
  bank_forced_a: assert property (fast_wr |-> ##2 effective_data_bank == 4'hf)
    else $error("fast or port bit bank not 15");
  ptr_bank_a: assert property (ptr_wr |-> ##2 effective_data_bank == 4'h0)
    else $error("restricted pointer bank not 0");
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench: AHB-Lite register calls walk the resolver's cases
// assumes oar_resolver as the only slave, its hreadyout fed back as hready
`timescale 1ns/1ps
`default_nettype none
module tb;
  import oar_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic operand_error;
  logic carry_bit_acc;
  logic [3:0] effective_data_bank;
  logic [7:0] wide_accumulator;
  logic [31:0] q;
  logic [15:0] cw;
  logic [12:0] pw;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  localparam logic [31:0] M_K = 32'h800f_0000;
  localparam logic [31:0] M_V = 32'h800f_ffff;
  always #4 hclk = ~hclk;
  oar_resolver dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .effective_data_bank(effective_data_bank), .operand_error(operand_error),
    .carry_bit_acc(carry_bit_acc), .wide_accumulator(wide_accumulator));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // read at the edge itself: the design moves only by non-blocking update
  task automatic wait_rdy;
    logic r;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(posedge hclk);
      r = hreadyout;
      q = hrdata;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    samples_checked++;
    if ((got & m) !== (e & m)) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic dec(input oar_class_t k, input logic [15:0] f, input logic [31:0] e,
      input logic [31:0] m);
    xfer(1'b1, OAR_CTRL_OFF, {16'h0, cw});
    xfer(1'b1, OAR_PC_OFF, {19'h0, pw});
    xfer(1'b1, OAR_OPND_OFF, {8'h0, f, 3'h0, k});
    repeat (3) @(posedge hclk);
    xfer(1'b0, OAR_RESULT_OFF, 32'h0);
    cmp(q, e, m);
    cmp({operand_error, 11'h0, effective_data_bank, 16'h0}, e, m & M_K);
  endtask
  task automatic bad(input oar_class_t k, input logic [15:0] f);
    dec(k, f, 32'h8000_0000, 32'h8000_0000);
  endtask
  task automatic ok(input oar_class_t k, input logic [15:0] f, input logic [3:0] b);
    dec(k, f, {12'h0, b, 16'h0}, M_K);
  endtask
  task automatic val(input oar_class_t k, input logic [15:0] f, input logic [31:0] e);
    dec(k, f, e, M_V);
  endtask
  // bit op (none for op 7), then accumulator readback and ports
  task automatic bop(input logic [2:0] op, input logic [1:0] b, input logic [8:0] e);
    if (op != 3'h7) xfer(1'b1, OAR_BITOP_OFF, {26'h0, b, 1'b0, op});
    repeat (3) @(posedge hclk);
    xfer(1'b0, OAR_ACC_OFF, 32'h0);
    cmp(q, {23'h0, e}, 32'h1ff);
    cmp({23'h0, carry_bit_acc, wide_accumulator}, {23'h0, e}, 32'h1ff);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, OAR_CTRL_OFF, 32'h0);
    cmp(q, {16'h0, OAR_CTRL_RESET}, 32'hffff);
    // select 3 and variant 3 refused, enable taken
    xfer(1'b1, OAR_CTRL_OFF, 32'h3031);
    xfer(1'b0, OAR_CTRL_OFF, 32'h0);
    cmp(q, 32'h1001, 32'hffff);
    xfer(1'b0, 8'h40, 32'h0);
    cmp(q, 32'h0, 32'hffff_ffff);
    xfer(1'b0, OAR_BITOP_OFF, 32'h0);
    cmp(q, 32'h0, 32'hffff_ffff);
    xfer(1'b1, OAR_ACC_OFF, 32'h0a5);
    bop(3'h7, 2'h0, 9'h0a5);
    bop(3'h0, 2'h2, 9'h1a5);
    bop(3'h1, 2'h1, 9'h1a7);
    bop(3'h4, 2'h0, 9'h0a7);
    bop(3'h3, 2'h2, 9'h1a7);
    bop(3'h2, 2'h3, 9'h0a7);
    bop(3'h5, 2'h0, 9'h1a7);
    bop(3'h6, 2'h0, 9'h0a7);
    cw = 16'h1000;
    pw = 13'h100;
    ok(OAR_C_REG, 16'h1, 4'h0);
    bad(OAR_C_NIBR, 16'h1);
    ok(OAR_C_NIBR, 16'h0, 4'h0);
    val(OAR_C_RP, 16'h3, 32'h3);
    bad(OAR_C_RP1, 16'h0);
    ok(OAR_C_RP1, 16'h1, 4'h0);
    bad(OAR_C_RP2, 16'h3);
    ok(OAR_C_RP2, 16'h1, 4'h0);
    ok(OAR_C_RPX, 16'h4, 4'h0);
    bad(OAR_C_RPX1, 16'h0);
    ok(OAR_C_RPX1, 16'h4, 4'h0);
    val(OAR_C_N4, 16'h5, 32'h5);
    val(OAR_C_N8, 16'ha5, 32'ha5);
    ok(OAR_C_BIT, 16'h3, 4'h0);
    val(OAR_C_MEM, 16'h80, 32'h000f_0f80);
    val(OAR_C_MEM, 16'h7f, 32'h7f);
    ok(OAR_C_RPA, 16'h1, 4'h0);
    ok(OAR_C_FMEM, 16'hfb0, 4'hf);
    ok(OAR_C_FMEM, 16'hfff, 4'hf);
    bad(OAR_C_FMEM, 16'hfc0);
    bad(OAR_C_FMEM, 16'hfaf);
    ok(OAR_C_PMEM, 16'hfc0, 4'hf);
    bad(OAR_C_PMEM, 16'hfbf);
    ok(OAR_C_ADDR, 16'hfff, 4'h0);
    bad(OAR_C_ADDR, 16'h1000);
    ok(OAR_C_FADDR, 16'h7ff, 4'h0);
    bad(OAR_C_FADDR, 16'h800);
    ok(OAR_C_TADDR, 16'h20, 4'h0);
    ok(OAR_C_TADDR, 16'h7e, 4'h0);
    bad(OAR_C_TADDR, 16'h21);
    bad(OAR_C_TADDR, 16'h1e);
    bad(OAR_C_TADDR, 16'h80);
    val(OAR_C_REL, 16'h31, 32'hf1);
    val(OAR_C_REL, 16'h3f, 32'hff);
    val(OAR_C_REL, 16'h02, 32'h102);
    val(OAR_C_REL, 16'h10, 32'h110);
    bad(OAR_C_REL, 16'h00);
    bad(OAR_C_REL, 16'h01);
    bad(OAR_C_REL, 16'h11);
    bad(OAR_C_REL, 16'h30);
    bad(OAR_C_PORT, 16'h4);
    ok(OAR_C_PORT, 16'h8, 4'h0);
    bad(OAR_C_PORT, 16'h9);
    ok(OAR_C_IE, 16'h8, 4'h0);
    bad(OAR_C_IE, 16'h9);
    ok(OAR_C_RB, 16'h3, 4'h0);
    bad(OAR_C_RB, 16'h4);
    ok(OAR_C_MEMBANK, 16'hf, 4'h0);
    bad(OAR_C_MEMBANK, 16'h1);
    cw = 16'h10f1;
    ok(OAR_C_RPA, 16'h0, 4'hf);
    ok(OAR_C_RPA, 16'h3, 4'h0);
    ok(OAR_C_RPTR, 16'h4, 4'h0);
    bad(OAR_C_RPTR, 16'h0);
    val(OAR_C_MEM, 16'h12, 32'h000f_0f12);
    val(OAR_C_MEM, 16'h7e, 32'h000f_0f7e);
    cw = 16'h1001;
    val(OAR_C_MEM, 16'h80, 32'h80);
    ok(OAR_C_PMEM, 16'hfff, 4'hf);
    cw = 16'h0000;
    ok(OAR_C_ADDR, 16'h7ff, 4'h0);
    bad(OAR_C_ADDR, 16'h800);
    bad(OAR_C_CADDR, 16'h800);
    cw = 16'h2000;
    pw = 13'h1000;
    ok(OAR_C_ADDR, 16'h1fff, 4'h0);
    val(OAR_C_CADDR, 16'habc, 32'h1abc);
    bad(OAR_C_CADDR, 16'h1000);
    pw = 13'h0;
    val(OAR_C_CADDR, 16'habc, 32'habc);
    complete_run;
  end
endmodule
bind oar_resolver oar_resolver_monitor mon (.*);
`default_nettype wire

// ---- verilog/oar_pkg.sv ----
// constants, operand classes and register map of the operand address resolver
// assumes a single hclk domain and an AHB-Lite register port
package oar_pkg;

  // register byte offsets
  localparam logic [7:0] OAR_CTRL_OFF = 8'h00;
  localparam logic [7:0] OAR_OPND_OFF = 8'h04;
  localparam logic [7:0] OAR_PC_OFF = 8'h08;
  localparam logic [7:0] OAR_RESULT_OFF = 8'h0c;
  localparam logic [7:0] OAR_ACC_OFF = 8'h10;
  localparam logic [7:0] OAR_BITOP_OFF = 8'h14;

  // control register fields
  localparam int OAR_CTRL_BANKEN_BIT = 0;
  localparam int OAR_CTRL_BANKSEL_LSB = 4;
  localparam int OAR_CTRL_RBANKEN_BIT = 8;
  localparam int OAR_CTRL_RBANKSEL_LSB = 9;
  localparam int OAR_CTRL_VAR_LSB = 12;

  // operand register fields: class low, operand field above
  localparam int OAR_OPND_FIELD_LSB = 8;

  // result word fields
  localparam int OAR_RES_ERR_BIT = 31;
  localparam int OAR_RES_BANK_LSB = 16;

  // bank numbers
  localparam logic [3:0] OAR_BANK_LOW = 4'h0;
  localparam logic [3:0] OAR_BANK_HIGH = 4'hf;

  // program memory variants and limits
  localparam logic [1:0] OAR_VAR_2K = 2'h0;
  localparam logic [1:0] OAR_VAR_4K = 2'h1;
  localparam logic [1:0] OAR_VAR_8K = 2'h2;
  localparam logic [12:0] OAR_LIM_2K = 13'h07ff;
  localparam logic [12:0] OAR_LIM_4K = 13'h0fff;
  localparam logic [12:0] OAR_LIM_8K = 13'h1fff;

  // data memory windows, table entry range, port and interrupt-enable limits
  localparam logic [11:0] OAR_FMEM_LO0 = 12'hfb0;
  localparam logic [11:0] OAR_FMEM_HI0 = 12'hfbf;
  localparam logic [11:0] OAR_FMEM_LO1 = 12'hff0;
  localparam logic [11:0] OAR_PMEM_LO = 12'hfc0;
  localparam logic [7:0] OAR_TADDR_LO = 8'h20;
  localparam logic [7:0] OAR_TADDR_HI = 8'h7f;
  localparam logic [3:0] OAR_IE_COUNT = 4'h9;
  localparam logic [3:0] OAR_PORT_GAP = 4'h4;
  localparam logic [3:0] OAR_PORT_MAX = 4'h8;

  // reset values
  localparam logic [15:0] OAR_CTRL_RESET = 16'h1000;

  typedef enum logic [4:0] {
    OAR_C_REG = 5'b00000, OAR_C_NIBR = 5'b00001, OAR_C_RP = 5'b00010,
    OAR_C_RP1 = 5'b00011, OAR_C_RP2 = 5'b00100, OAR_C_RPX = 5'b00101,
    OAR_C_RPX1 = 5'b00110, OAR_C_RPA = 5'b00111, OAR_C_RPTR = 5'b01000,
    OAR_C_N4 = 5'b01001, OAR_C_N8 = 5'b01010, OAR_C_MEM = 5'b01011,
    OAR_C_BIT = 5'b01100, OAR_C_FMEM = 5'b01101, OAR_C_PMEM = 5'b01110,
    OAR_C_ADDR = 5'b01111, OAR_C_CADDR = 5'b10000, OAR_C_FADDR = 5'b10001,
    OAR_C_TADDR = 5'b10010, OAR_C_REL = 5'b10011, OAR_C_PORT = 5'b10100,
    OAR_C_IE = 5'b10101, OAR_C_RB = 5'b10110, OAR_C_MEMBANK = 5'b10111
  } oar_class_t;

  typedef enum logic [2:0] {
    OAR_B_LOAD = 3'b000, OAR_B_STORE = 3'b001, OAR_B_AND = 3'b010,
    OAR_B_OR = 3'b011, OAR_B_XOR = 3'b100, OAR_B_SET = 3'b101, OAR_B_CLR = 3'b110
  } oar_bitop_t;

endpackage

// ---- verilog/oar_resolver.sv ----
// operand address resolver: operand decode, bank choice, branch target
// ranges and the accumulator/carry state, all behind an AHB-Lite slave
// assumes one slave on the bus (hreadyout is hready) and single word transfers
//
// Notes on behaviour
// - nibble selectors; restricted one excludes accumulator
// - pair selector classes, primed reach expanded pairs
// - pointer classes; restricted pointer only DE, DL
// - short immediates 4 bits, long 8 bits
// - direct address 8 bits, bit field 2
// - fast bit operand only FB0-FBF, FF0-FFF
// - L-indexed port bit only FC0-FFF
// - fast and port-bit operands force bank 15
// - DE and DL pointers always bank 0
// - absolute targets limited by program size variant
// - compact target 12 bits, keeps top bit on the 8K variant only
// - far call 11 bits, below 800H
// - table entry even, 20H to 7FH
// - relative reach -15..-1 or +2..+16
// - port and interrupt-enable operand sets
// - register bank 0-3, memory bank 0/15
// - A nibble accumulator, X:A wide accumulator
// - carry serves as bit accumulator
//
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module oar_resolver
  import oar_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [3:0] effective_data_bank,
  output logic operand_error,
  output logic carry_bit_acc,
  output logic [7:0] wide_accumulator
);

  typedef struct packed {
    logic bank_enable_flag;
    logic [3:0] data_bank_select;
    logic regbank_enable_flag;
    logic [1:0] regbank_select;
    logic [1:0] variant;
    logic [4:0] opnd_class;
    logic [15:0] opnd_field;
    logic [12:0] pc;
    logic [3:0] acc_a;
    logic [3:0] acc_x;
    logic carry;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
    logic [3:0] bank_out;
    logic err_out;
    logic [7:0] wide_out;
  } oar_state_t;

  oar_state_t st_reg;
  oar_state_t st_next;

  ////////////////////////////////////////////////////////////////////////
  // operand decode: result is {err, bank, value}
  function automatic logic [31:0] oar_decode(
    input logic [4:0] cls,
    input logic [15:0] f,
    input logic [12:0] pc,
    input logic bank_en,
    input logic [3:0] bank_sel,
    input logic [1:0] vsel
  );
    logic ok;
    logic [3:0] bank;
    logic [15:0] val;
    logic [12:0] lim;
    logic [12:0] rel;
    logic [3:0] hl_bank;
    ok = 1'b1;
    bank = OAR_BANK_LOW;
    val = 16'h0000;
    lim = (vsel == OAR_VAR_2K) ? OAR_LIM_2K :
          (vsel == OAR_VAR_4K) ? OAR_LIM_4K : OAR_LIM_8K;
    // target wraps inside 13 bits; legality rests on the field alone
    rel = pc + {{7{f[5]}}, f[5:0]};
    hl_bank = bank_en ? bank_sel : OAR_BANK_LOW;
    case (cls)
      OAR_C_REG: begin
        val = {13'h0000, f[2:0]};
      end
      OAR_C_NIBR: begin
        val = {13'h0000, f[2:0]};
        ok = (f[2:0] != 3'h1);
      end
      OAR_C_RP: begin
        val = {14'h0000, f[1:0]};
      end
      OAR_C_RP1: begin
        val = {14'h0000, f[1:0]};
        ok = (f[1:0] != 2'h0);
      end
      OAR_C_RP2: begin
        val = {14'h0000, f[1:0]};
        ok = (f[1:0] == 2'h1) || (f[1:0] == 2'h2);
      end
      OAR_C_RPX: begin
        val = {13'h0000, f[2:0]};
      end
      OAR_C_RPX1: begin
        val = {13'h0000, f[2:0]};
        ok = (f[2:0] != 3'h0);
      end
      OAR_C_RPA: begin
        // 0 HL, 1 HL+, 2 HL-, 3 DE, 4 DL
        val = {13'h0000, f[2:0]};
        ok = (f[2:0] <= 3'h4);
        bank = (f[2:0] >= 3'h3) ? OAR_BANK_LOW : hl_bank;
      end
      OAR_C_RPTR: begin
        val = {13'h0000, f[2:0]};
        ok = (f[2:0] == 3'h3) || (f[2:0] == 3'h4);
        bank = OAR_BANK_LOW;
      end
      OAR_C_N4: begin
        val = {12'h000, f[3:0]};
      end
      OAR_C_N8: begin
        val = {8'h00, f[7:0]};
      end
      OAR_C_MEM: begin
        // disabled bank: low half maps to bank 0, high half to bank 15
        if (bank_en) begin
          bank = bank_sel;
        end else begin
          bank = f[7] ? OAR_BANK_HIGH : OAR_BANK_LOW;
        end
        val = {4'h0, bank, f[7:0]};
      end
      OAR_C_BIT: begin
        val = {14'h0000, f[1:0]};
      end
      OAR_C_FMEM: begin
        val = {4'h0, f[11:0]};
        ok = ((f[11:0] >= OAR_FMEM_LO0) && (f[11:0] <= OAR_FMEM_HI0)) ||
             (f[11:0] >= OAR_FMEM_LO1);
        bank = OAR_BANK_HIGH;
      end
      OAR_C_PMEM: begin
        val = {4'h0, f[11:0]};
        ok = (f[11:0] >= OAR_PMEM_LO);
        bank = OAR_BANK_HIGH;
      end
      OAR_C_ADDR: begin
        val = {3'h0, f[12:0]};
        ok = (f[12:0] <= lim) && (f[15:13] == 3'h0);
      end
      OAR_C_CADDR: begin
        // top program counter bit survives only on the largest variant
        val = {3'h0, (vsel == OAR_VAR_8K) ? pc[12] : 1'b0, f[11:0]};
        ok = (f[15:12] == 4'h0) && (val[12:0] <= lim);
      end
      OAR_C_FADDR: begin
        val = {5'h00, f[10:0]};
        ok = (f[15:11] == 5'h00);
      end
      OAR_C_TADDR: begin
        val = {8'h00, f[7:0]};
        ok = (f[7:0] >= OAR_TADDR_LO) && (f[7:0] <= OAR_TADDR_HI) &&
             !f[0] && (f[15:8] == 8'h00);
      end
      OAR_C_REL: begin
        val = {3'h0, rel};
        ok = ($signed(f[5:0]) >= -6'sd15 && $signed(f[5:0]) <= -6'sd1) ||
             ($signed(f[5:0]) >= 6'sd2 && $signed(f[5:0]) <= 6'sd16);
      end
      OAR_C_PORT: begin
        val = {12'h000, f[3:0]};
        ok = (f[3:0] <= OAR_PORT_MAX) && (f[3:0] != OAR_PORT_GAP);
      end
      OAR_C_IE: begin
        // 0 timer base, 1..3 timers, 4..6 ext 0-2, 7 ext 4, 8 serial
        val = {12'h000, f[3:0]};
        ok = (f[3:0] < OAR_IE_COUNT);
      end
      OAR_C_RB: begin
        val = {14'h0000, f[1:0]};
        ok = (f[15:2] == 14'h0000);
      end
      OAR_C_MEMBANK: begin
        val = {12'h000, f[3:0]};
        ok = (f[3:0] == OAR_BANK_LOW) || (f[3:0] == OAR_BANK_HIGH);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    oar_decode = {~ok, 11'h000, bank, val};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [31:0] dec;
    logic [31:0] wd;
    logic [2:0] bop;
    logic [1:0] bsel;
    dec = 32'h0000_0000;
    wd = hwdata;
    bop = hwdata[2:0];
    bsel = hwdata[5:4];
    st_next = st_reg;
    dec = oar_decode(st_reg.opnd_class, st_reg.opnd_field, st_reg.pc,
                     st_reg.bank_enable_flag, st_reg.data_bank_select, st_reg.variant);

    // write data phase
    if (st_reg.wr_pend) begin
      case (st_reg.dp_addr)
        OAR_CTRL_OFF: begin
          st_next.bank_enable_flag = wd[OAR_CTRL_BANKEN_BIT];
          // only banks 0 and 15 exist for the select; other values are dropped
          if (wd[OAR_CTRL_BANKSEL_LSB +: 4] == OAR_BANK_LOW ||
              wd[OAR_CTRL_BANKSEL_LSB +: 4] == OAR_BANK_HIGH) begin
            st_next.data_bank_select = wd[OAR_CTRL_BANKSEL_LSB +: 4];
          end
          st_next.regbank_enable_flag = wd[OAR_CTRL_RBANKEN_BIT];
          st_next.regbank_select = wd[OAR_CTRL_RBANKSEL_LSB +: 2];
          if (wd[OAR_CTRL_VAR_LSB +: 2] != 2'h3) begin
            st_next.variant = wd[OAR_CTRL_VAR_LSB +: 2];
          end
        end
        OAR_OPND_OFF: begin
          st_next.opnd_class = wd[4:0];
          st_next.opnd_field = wd[OAR_OPND_FIELD_LSB +: 16];
        end
        OAR_PC_OFF: begin
          st_next.pc = wd[12:0];
        end
        OAR_ACC_OFF: begin
          st_next.acc_a = wd[3:0];
          st_next.acc_x = wd[7:4];
          st_next.carry = wd[8];
        end
        OAR_BITOP_OFF: begin
          case (bop)
            OAR_B_LOAD: begin
              st_next.carry = st_reg.acc_a[bsel];
            end
            OAR_B_STORE: begin
              st_next.acc_a[bsel] = st_reg.carry;
            end
            OAR_B_AND: begin
              st_next.carry = st_reg.carry & st_reg.acc_a[bsel];
            end
            OAR_B_OR: begin
              st_next.carry = st_reg.carry | st_reg.acc_a[bsel];
            end
            OAR_B_XOR: begin
              st_next.carry = st_reg.carry ^ st_reg.acc_a[bsel];
            end
            OAR_B_SET: begin
              st_next.carry = 1'b1;
            end
            OAR_B_CLR: begin
              st_next.carry = 1'b0;
            end
            default: begin
              st_next.carry = st_reg.carry;
            end
          endcase
        end
        default: begin
          st_next.carry = st_reg.carry;
        end
      endcase
    end

    // read data phase: one wait state so a just-written value is seen
    st_next.ready = 1'b1;
    if (st_reg.rd_pend) begin
      case (st_reg.dp_addr)
        OAR_CTRL_OFF: st_next.rdata = {16'h0000, 2'h0, st_reg.variant, 1'b0,
                                       st_reg.regbank_select, st_reg.regbank_enable_flag,
                                       st_reg.data_bank_select, 3'h0,
                                       st_reg.bank_enable_flag};
        OAR_OPND_OFF: st_next.rdata = {8'h00, st_reg.opnd_field, 3'h0, st_reg.opnd_class};
        OAR_PC_OFF: st_next.rdata = {19'h00000, st_reg.pc};
        OAR_RESULT_OFF: st_next.rdata = dec;
        OAR_ACC_OFF: st_next.rdata = {23'h000000, st_reg.carry, st_reg.acc_x, st_reg.acc_a};
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // address phase
    // hready low in a read wait state keeps a second request out
    st_next.wr_pend = 1'b0;
    st_next.rd_pend = 1'b0;
    if (hready && hsel && htrans[1]) begin
      st_next.dp_addr = haddr[7:0];
      st_next.wr_pend = hwrite;
      st_next.rd_pend = !hwrite;
      st_next.ready = hwrite;
    end

    // decode outputs lag the operand write by one edge, like a RESULT read
    st_next.bank_out = dec[OAR_RES_BANK_LSB +: 4];
    st_next.err_out = dec[OAR_RES_ERR_BIT];
    st_next.wide_out = {st_next.acc_x, st_next.acc_a};
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.bank_enable_flag <= OAR_CTRL_RESET[OAR_CTRL_BANKEN_BIT];
      st_reg.variant <= OAR_CTRL_RESET[OAR_CTRL_VAR_LSB +: 2];
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ports other than hresp (tied to 0) are plain register fields: no logic between flop and pin
  assign hrdata = st_reg.rdata;
  assign hreadyout = st_reg.ready;
  assign hresp = 1'b0;
  assign effective_data_bank = st_reg.bank_out;
  assign operand_error = st_reg.err_out;
  assign carry_bit_acc = st_reg.carry;
  assign wide_accumulator = st_reg.wide_out;

endmodule

`default_nettype wire
